// ---- rtl/branch_target_unit.sv ----
// Branch execution unit: targets, conditions, link and loop-count updates
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "branch_target_unit_regs.svh"

module branch_target_unit (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Branch request
  input  wire logic                       req_valid,
  input  wire branch_target_pkg::branch_req_t req,
  // Branch result
  output logic                            res_valid,
  output branch_target_pkg::branch_res_t  res,
  // Architectural state seen by the core
  output logic [63:0]                     return_address_reg,
  output logic [63:0]                     loop_count_reg,
  // Register port
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic [31:0]                     reg_rdata
);

  // ****************************************
  // Decode
  // ****************************************
  branch_target_pkg::branch_op_t op;
  logic        is_link;
  logic        is_abs;
  logic        is_cond;
  logic        is_to_ret;
  logic        is_to_loop;
  logic        form_invalid;
  logic [63:0] seq_addr;
  logic [63:0] target;
  logic [63:0] reg_target;
  logic [63:0] loop_dec;
  logic        cond_taken;
  logic        cond_dec;
  logic        mode32;
  logic [31:0] condition_flags_reg;
  logic [31:0] invalid_count;
  logic [31:0] taken_count;
  logic        do_dec;
  logic        do_link;
  logic        final_taken;

  assign op = req.op;

  always_comb begin
    is_link    = 1'b0;
    is_abs     = 1'b0;
    is_cond    = 1'b1;
    is_to_ret  = 1'b0;
    is_to_loop = 1'b0;
    case (op)
      branch_target_pkg::OP_REL_JUMP: begin
        is_cond = 1'b0;
      end
      branch_target_pkg::OP_ABS_JUMP: begin
        is_cond = 1'b0;
        is_abs  = 1'b1;
      end
      branch_target_pkg::OP_REL_JUMP_LINK: begin
        is_cond = 1'b0;
        is_link = 1'b1;
      end
      branch_target_pkg::OP_ABS_JUMP_LINK: begin
        is_cond = 1'b0;
        is_abs  = 1'b1;
        is_link = 1'b1;
      end
      branch_target_pkg::OP_COND_ABS_JUMP: begin
        is_abs = 1'b1;
      end
      branch_target_pkg::OP_COND_REL_JUMP_LINK: begin
        is_link = 1'b1;
      end
      branch_target_pkg::OP_COND_ABS_JUMP_LINK: begin
        is_abs  = 1'b1;
        is_link = 1'b1;
      end
      branch_target_pkg::OP_COND_TO_RETURN: begin
        is_to_ret = 1'b1;
      end
      branch_target_pkg::OP_COND_TO_RETURN_LINK: begin
        is_to_ret = 1'b1;
        is_link   = 1'b1;
      end
      branch_target_pkg::OP_COND_TO_LOOP: begin
        is_to_loop = 1'b1;
      end
      branch_target_pkg::OP_COND_TO_LOOP_LINK: begin
        is_to_loop = 1'b1;
        is_link    = 1'b1;
      end
      default: begin
        is_cond = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Condition and target
  // ****************************************
  branch_condition i_branch_condition (
    .branch_options      (req.branch_options),
    .cond_flag_index     (req.cond_flag_index),
    .condition_flags_reg (condition_flags_reg),
    .loop_count_reg      (loop_count_reg),
    .mode32              (mode32),
    .taken               (cond_taken),
    .decrement           (cond_dec),
    .next_loop_count     (loop_dec)
  );

  // The loop-register form cannot both count and jump through the counter
  assign form_invalid = is_to_loop & ~req.branch_options[4 - `BTU_BO_NO_DEC];

  assign seq_addr = req.insn_addr + `BTU_INSN_BYTES;

  always_comb begin
    reg_target = is_to_ret ? {return_address_reg[63:2], 2'b00}
                           : {loop_count_reg[63:2], 2'b00};
    if (mode32) begin
      reg_target[63:32] = 32'h00000000;
    end
    if (is_to_ret || is_to_loop) begin
      target = reg_target;
    end else if (is_abs) begin
      target = req.displacement;
    end else begin
      target = req.insn_addr + req.displacement;
    end
  end

  assign final_taken = ~form_invalid & (~is_cond | cond_taken);
  assign do_dec      = req_valid & ~form_invalid & is_cond & cond_dec;
  assign do_link     = req_valid & ~form_invalid & is_link;

  // ****************************************
  // Result register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid <= 1'b0;
    end else begin
      res_valid <= req_valid;
    end
  end

  // Target uses the pre-update return register, so the link write cannot corrupt it
  always_ff @(posedge clk) begin
    if (rst) begin
      res <= '0;
    end else if (req_valid) begin
      res.taken      <= final_taken;
      res.invalid    <= form_invalid;
      res.next_fetch <= final_taken ? target : seq_addr;
      res.hint       <= (is_to_ret || is_to_loop) ? req.target_use_hint : 2'b00;
    end
  end

  // ****************************************
  // Architectural registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      return_address_reg <= `BTU_RST_WORD64;
    end else if (do_link) begin
      return_address_reg <= seq_addr;
    end else if (reg_write && reg_addr == `BTU_OFS_RET_LO) begin
      return_address_reg[31:0] <= reg_wdata;
    end else if (reg_write && reg_addr == `BTU_OFS_RET_HI) begin
      return_address_reg[63:32] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loop_count_reg <= `BTU_RST_WORD64;
    end else if (do_dec) begin
      loop_count_reg <= loop_dec;
    end else if (reg_write && reg_addr == `BTU_OFS_LOOP_LO) begin
      loop_count_reg[31:0] <= reg_wdata;
    end else if (reg_write && reg_addr == `BTU_OFS_LOOP_HI) begin
      loop_count_reg[63:32] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      condition_flags_reg <= `BTU_RST_WORD32;
      mode32              <= 1'b0;
    end else if (reg_write && reg_addr == `BTU_OFS_FLAGS) begin
      condition_flags_reg <= reg_wdata;
    end else if (reg_write && reg_addr == `BTU_OFS_MODE) begin
      mode32 <= reg_wdata[0];
    end
  end

  // Status counters wrap; software takes differences
  always_ff @(posedge clk) begin
    if (rst) begin
      invalid_count <= `BTU_RST_WORD32;
      taken_count   <= `BTU_RST_WORD32;
    end else if (req_valid) begin
      invalid_count <= invalid_count + {31'h00000000, form_invalid};
      taken_count   <= taken_count + {31'h00000000, final_taken};
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `BTU_RST_WORD32;
    end else if (reg_read) begin
      if (reg_addr == `BTU_OFS_RET_LO) begin
        reg_rdata <= return_address_reg[31:0];
      end else if (reg_addr == `BTU_OFS_RET_HI) begin
        reg_rdata <= return_address_reg[63:32];
      end else if (reg_addr == `BTU_OFS_LOOP_LO) begin
        reg_rdata <= loop_count_reg[31:0];
      end else if (reg_addr == `BTU_OFS_LOOP_HI) begin
        reg_rdata <= loop_count_reg[63:32];
      end else if (reg_addr == `BTU_OFS_FLAGS) begin
        reg_rdata <= condition_flags_reg;
      end else if (reg_addr == `BTU_OFS_MODE) begin
        reg_rdata <= {31'h00000000, mode32};
      end else if (reg_addr == `BTU_OFS_STATUS) begin
        reg_rdata <= {invalid_count[15:0], taken_count[15:0]};
      end else begin
        reg_rdata <= `BTU_RST_WORD32;
      end
    end else begin
      reg_rdata <= `BTU_RST_WORD32;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_REL_TARGET: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_REL_JUMP
    |=> res.next_fetch == $past(req.insn_addr) + $past(req.displacement))
    else $error("relative target wrong");

  AST_ABS_TARGET: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_ABS_JUMP |=> res.next_fetch == $past(req.displacement))
    else $error("absolute target wrong");

  AST_LINK_LOAD: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_REL_JUMP_LINK
    |=> return_address_reg == $past(req.insn_addr) + 64'h0000000000000004)
    else $error("link not loaded");

  AST_RET_LOW_BITS: assert property (@(posedge clk) disable iff (rst)
    res_valid && res.taken && $past(is_to_ret) |-> res.next_fetch[1:0] == 2'b00)
    else $error("return target low bits set");

  AST_MODE32_UPPER: assert property (@(posedge clk) disable iff (rst)
    res_valid && res.taken && $past(mode32) && $past(is_to_loop) |-> res.next_fetch[63:32] == 32'h00000000)
    else $error("upper target bits not cleared");

  AST_RET_LINK_ORDER: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_COND_TO_RETURN_LINK && !mode32 && final_taken
    |=> res.next_fetch == {$past(return_address_reg[63:2]), 2'b00})
    else $error("return link used new value");

  AST_LOOP_INVALID: assert property (@(posedge clk) disable iff (rst)
    req_valid && is_to_loop && !req.branch_options[2] |=> res.invalid && !res.taken && $stable(loop_count_reg))
    else $error("invalid loop form accepted");

  AST_DECREMENT: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_COND_REL_JUMP && !req.branch_options[2]
    |=> loop_count_reg == $past(loop_count_reg) - 64'h0000000000000001)
    else $error("loop count not decremented");

  AST_NOT_TAKEN: assert property (@(posedge clk) disable iff (rst)
    res_valid && !res.taken |-> res.next_fetch == $past(req.insn_addr) + 64'h0000000000000004)
    else $error("not-taken address wrong");

  AST_LOOP_TARGET: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_COND_TO_LOOP && !mode32 && final_taken
    |=> res.next_fetch == {$past(loop_count_reg[63:2]), 2'b00})
    else $error("loop register target wrong");

  AST_LOOP_LINK: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_COND_TO_LOOP_LINK && req.branch_options[2]
    |=> return_address_reg == $past(req.insn_addr) + 64'h0000000000000004)
    else $error("loop link did not load return register");

  AST_FLAG_SELECT: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == branch_target_pkg::OP_COND_REL_JUMP && req.branch_options == 5'h0C
    |=> res.taken == $past(condition_flags_reg[5'h1F - req.cond_flag_index]))
    else $error("wrong condition bit tested");

  AST_HINT_PASS: assert property (@(posedge clk) disable iff (rst)
    req_valid && (is_to_ret || is_to_loop) |=> res.hint == $past(req.target_use_hint))
    else $error("usage hint not passed");

  AST_ALWAYS_TAKEN: assert property (@(posedge clk) disable iff (rst)
    req_valid && is_cond && req.branch_options[4] && req.branch_options[2] |=> res.taken)
    else $error("branch-always form not taken");

  AST_LINK_NEXT: assert property (@(posedge clk) disable iff (rst)
    req_valid && is_link && !form_invalid |=> return_address_reg == $past(req.insn_addr) + 64'h0000000000000004)
    else $error("link address wrong");

  AST_INVALID_NO_LINK: assert property (@(posedge clk) disable iff (rst)
    req_valid && form_invalid && !reg_write |=> $stable(return_address_reg))
    else $error("invalid form changed return register");

  COV_TAKEN_LOOP: cover property (@(posedge clk) disable iff (rst) res_valid && res.taken && $past(is_to_loop));
  COV_NOT_TAKEN:  cover property (@(posedge clk) disable iff (rst) res_valid && !res.taken && !res.invalid);
  COV_INVALID:    cover property (@(posedge clk) disable iff (rst) res_valid && res.invalid);
  COV_VAR_CALL:   cover property (@(posedge clk) disable iff (rst) res_valid && res.taken && res.hint == 2'h3);
  COV_MODE32_DEC: cover property (@(posedge clk) disable iff (rst) req_valid && mode32 && do_dec);

endmodule

// ---- rtl/branch_target_unit_regs.svh ----
// Constants for the branch target unit: field positions, encodings and reset values
`ifndef BRANCH_TARGET_UNIT_REGS_SVH
`define BRANCH_TARGET_UNIT_REGS_SVH

// ****************************************
// Register port offsets
// ****************************************
`define BTU_OFS_RET_LO      4'h0
`define BTU_OFS_RET_HI      4'h1
`define BTU_OFS_LOOP_LO     4'h2
`define BTU_OFS_LOOP_HI     4'h3
`define BTU_OFS_FLAGS       4'h4
`define BTU_OFS_MODE        4'h5
`define BTU_OFS_STATUS      4'h6

// ****************************************
// Option field bit positions (bit 0 is the most significant, as printed)
// ****************************************
`define BTU_BO_NO_COND      0
`define BTU_BO_COND_TRUE    1
`define BTU_BO_NO_DEC       2
`define BTU_BO_ZERO_TEST    3

// ****************************************
// Reset values, hint encoding and instruction size
// ****************************************
`define BTU_RST_WORD64      64'h0000000000000000
`define BTU_RST_WORD32      32'h00000000
`define BTU_HINT_NOT_PRED   2'h3
`define BTU_INSN_BYTES      64'h0000000000000004

`endif

// ---- rtl/branch_target_pkg.sv ----
// Types for the branch target unit
package branch_target_pkg;

  typedef enum logic [3:0] {
    OP_REL_JUMP              = 4'h0,
    OP_ABS_JUMP              = 4'h1,
    OP_REL_JUMP_LINK         = 4'h2,
    OP_ABS_JUMP_LINK         = 4'h3,
    OP_COND_REL_JUMP         = 4'h4,
    OP_COND_ABS_JUMP         = 4'h5,
    OP_COND_REL_JUMP_LINK    = 4'h6,
    OP_COND_ABS_JUMP_LINK    = 4'h7,
    OP_COND_TO_RETURN        = 4'h8,
    OP_COND_TO_RETURN_LINK   = 4'h9,
    OP_COND_TO_LOOP          = 4'hA,
    OP_COND_TO_LOOP_LINK     = 4'hB
  } branch_op_t;

  typedef struct packed {
    branch_op_t  op;
    logic [4:0]  branch_options;
    logic [4:0]  cond_flag_index;
    logic [1:0]  target_use_hint;
    logic [63:0] insn_addr;
    logic [63:0] displacement;
  } branch_req_t;

  typedef struct packed {
    logic        taken;
    logic        invalid;
    logic [63:0] next_fetch;
    logic [1:0]  hint;
  } branch_res_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ANSWER = 2'b01
  } unit_state_t;

endpackage

// ---- rtl/branch_condition.sv ----
// Branch condition evaluation from option field, flag bit and loop count
`timescale 1ns/1ps
`include "branch_target_unit_regs.svh"

module branch_condition (
  // Instruction fields
  input  wire logic [4:0]  branch_options,
  input  wire logic [4:0]  cond_flag_index,
  // State
  input  wire logic [31:0] condition_flags_reg,
  input  wire logic [63:0] loop_count_reg,
  input  wire logic        mode32,
  // Results
  output logic             taken,
  output logic             decrement,
  output logic [63:0]      next_loop_count
);

  logic        flag_bit;
  logic        ctr_zero;
  logic        ctr_ok;
  logic        cond_ok;
  logic [31:0] flag_lsb;

  // Bit 0 of the flags is the most significant, so index from the top
  always_comb begin
    flag_lsb = condition_flags_reg;
    flag_bit = flag_lsb[5'd31 - cond_flag_index];
  end

  // Whole 64-bit register decrements in either mode when option bit BTU_BO_NO_DEC is clear; only the test narrows in 32-bit mode
  assign decrement       = ~branch_options[4 - `BTU_BO_NO_DEC];
  assign next_loop_count = decrement ? loop_count_reg - 64'h0000000000000001 : loop_count_reg;
  assign ctr_zero        = mode32 ? (next_loop_count[31:0] == 32'h00000000)
                                  : (next_loop_count == 64'h0000000000000000);
  assign ctr_ok  = ~decrement | (ctr_zero == branch_options[4 - `BTU_BO_ZERO_TEST]);
  assign cond_ok = branch_options[4 - `BTU_BO_NO_COND] |
                   (flag_bit == branch_options[4 - `BTU_BO_COND_TRUE]);
  assign taken   = ctr_ok & cond_ok;

endmodule

// ---- verification/branch_stream.sv ----
// Instruction stream model: issues branch requests to the branch target unit
`timescale 1ns/1ps

module branch_stream (
  // Clock
  input  wire logic                      clk,
  // Request to the unit
  output logic                           req_valid,
  output branch_target_pkg::branch_req_t req
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // ****************************************
  // One branch, one cycle
  // ****************************************
  task automatic send(input branch_target_pkg::branch_op_t op, input logic [4:0] bo, input logic [4:0] bi,
                      input logic [1:0] bh, input logic [63:0] ia, input logic [63:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{op, bo, bi, bh, ia, d};
    @(posedge clk);
    req_valid <= 1'b0;
    // Released fields show garbage so a stale request is never mistaken for a live one
    req       <= branch_target_pkg::branch_req_t'(~req);
  endtask

  // ****************************************
  // Calling conventions of compiled code
  // ****************************************
  task automatic glue_jump(input logic [63:0] ia);
    send(branch_target_pkg::OP_COND_TO_LOOP, 5'h14, 5'h00, 2'h0, ia, 64'h0);
  endtask

  task automatic var_call(input logic [63:0] ia);
    send(branch_target_pkg::OP_COND_TO_LOOP_LINK, 5'h14, 5'h00, 2'h3, ia, 64'h0);
  endtask
endmodule

// ---- verification/branch_target_unit_tb.sv ----
// Self-checking testbench for the branch target unit
`timescale 1ns/1ps

module branch_target_unit_tb;
  logic                           clk;
  logic                           rst;
  logic                           req_valid;
  branch_target_pkg::branch_req_t req;
  logic                           res_valid;
  branch_target_pkg::branch_res_t res;
  logic [63:0]                    return_address_reg;
  logic [63:0]                    loop_count_reg;
  logic [3:0]                     reg_addr;
  logic [31:0]                    reg_wdata;
  logic                           reg_write;
  logic                           reg_read;
  logic [31:0]                    reg_rdata;
  logic [31:0]                    rd;
  int                             fail_count;
  int                             comparisons;

  branch_target_unit i_branch_target_unit (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res),
    .return_address_reg(return_address_reg), .loop_count_reg(loop_count_reg), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
  );

  branch_stream i_branch_stream (.clk(clk), .req_valid(req_valid), .req(req));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic set_ret(input logic [63:0] v);
    reg_wr(4'h0, v[31:0]);
    reg_wr(4'h1, v[63:32]);
  endtask

  task automatic set_loop(input logic [63:0] v);
    reg_wr(4'h2, v[31:0]);
    reg_wr(4'h3, v[63:32]);
  endtask

  // Result stands one cycle after the request edge, looked at in that cycle
  task automatic br(input branch_target_pkg::branch_op_t op, input logic [4:0] bo, input logic [4:0] bi,
                    input logic [63:0] ia, input logic [63:0] d, input logic tk, input logic [63:0] nf);
    i_branch_stream.send(op, bo, bi, 2'h1, ia, d);
    #1;
    chk(res_valid, 1'b1);
    chk(res.taken, tk);
    chk(res.next_fetch, nf);
  endtask

  task automatic end_of_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_immediate;
    br(branch_target_pkg::OP_REL_JUMP, 5'h00, 5'h00, 64'h1000, 64'hFFFFFFFFFFFFFFF0, 1'b1, 64'hFF0);
    chk(return_address_reg, 64'h0);
    br(branch_target_pkg::OP_ABS_JUMP, 5'h00, 5'h00, 64'h2000, 64'h400, 1'b1, 64'h400);
    br(branch_target_pkg::OP_REL_JUMP_LINK, 5'h00, 5'h00, 64'h3000, 64'h100, 1'b1, 64'h3100);
    chk(return_address_reg, 64'h3004);
    br(branch_target_pkg::OP_ABS_JUMP_LINK, 5'h00, 5'h00, 64'h4000, 64'h80, 1'b1, 64'h80);
    chk(return_address_reg, 64'h4004);
    $display("Test immediate forms done");
  endtask

  task automatic t_condition;
    reg_wr(4'h4, 32'h80000001);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h0C, 5'h00, 64'h100, 64'h40, 1'b1, 64'h140);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h0C, 5'h01, 64'h100, 64'h40, 1'b0, 64'h104);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h04, 5'h1F, 64'h200, 64'h40, 1'b0, 64'h204);
    br(branch_target_pkg::OP_COND_ABS_JUMP_LINK, 5'h04, 5'h1E, 64'h300, 64'h40, 1'b1, 64'h40);
    chk(return_address_reg, 64'h304);
    br(branch_target_pkg::OP_COND_REL_JUMP_LINK, 5'h0C, 5'h1E, 64'h400, 64'h40, 1'b0, 64'h404);
    chk(return_address_reg, 64'h404);
    $display("Test condition bits done");
  endtask

  task automatic t_decrement;
    set_loop(64'h1);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h12, 5'h00, 64'h500, 64'h20, 1'b1, 64'h520);
    chk(loop_count_reg, 64'h0);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h12, 5'h00, 64'h500, 64'h20, 1'b0, 64'h504);
    chk(loop_count_reg, 64'hFFFFFFFFFFFFFFFF);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h10, 5'h00, 64'h500, 64'h20, 1'b1, 64'h520);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h08, 5'h00, 64'h500, 64'h20, 1'b1, 64'h520);
    chk(loop_count_reg, 64'hFFFFFFFFFFFFFFFD);
    reg_wr(4'h5, 32'h1);
    set_loop(64'h100000001);
    br(branch_target_pkg::OP_COND_REL_JUMP, 5'h12, 5'h00, 64'h600, 64'h20, 1'b1, 64'h620);
    chk(loop_count_reg, 64'h100000000);
    reg_wr(4'h5, 32'h0);
    $display("Test loop count decrement done");
  endtask

  task automatic t_register_targets;
    set_ret(64'h123456789ABCDEF3);
    br(branch_target_pkg::OP_COND_TO_RETURN, 5'h14, 5'h00, 64'h900, 64'h0, 1'b1, 64'h123456789ABCDEF0);
    chk(res.hint, 2'h1);
    br(branch_target_pkg::OP_COND_TO_RETURN_LINK, 5'h14, 5'h00, 64'h5000, 64'h0, 1'b1, 64'h123456789ABCDEF0);
    chk(return_address_reg, 64'h5004);
    set_loop(64'hAAAABBBBCCCCDDD6);
    i_branch_stream.glue_jump(64'h6000);
    #1;
    chk(res.next_fetch, 64'hAAAABBBBCCCCDDD4);
    chk(return_address_reg, 64'h5004);
    i_branch_stream.var_call(64'h7000);
    #1;
    chk(res.next_fetch, 64'hAAAABBBBCCCCDDD4);
    chk(return_address_reg, 64'h7004);
    chk(res.hint, 2'h3);
    reg_wr(4'h5, 32'h1);
    br(branch_target_pkg::OP_COND_TO_LOOP, 5'h14, 5'h00, 64'h7100, 64'h0, 1'b1, 64'hCCCCDDD4);
    // Upper half set so that a missing clear would show
    reg_wr(4'h1, 32'hFFFF0000);
    br(branch_target_pkg::OP_COND_TO_RETURN, 5'h14, 5'h00, 64'h7200, 64'h0, 1'b1, 64'h7004);
    reg_wr(4'h1, 32'h0);
    reg_wr(4'h5, 32'h0);
    br(branch_target_pkg::OP_COND_TO_LOOP, 5'h10, 5'h00, 64'h8000, 64'h0, 1'b0, 64'h8004);
    chk(res.invalid, 1'b1);
    chk(loop_count_reg, 64'hAAAABBBBCCCCDDD6);
    $display("Test register targets done");
  endtask

  task automatic t_reg_port;
    reg_rd(4'h4);
    chk(rd, 32'h80000001);
    reg_rd(4'h1);
    chk(rd, 32'h0);
    reg_rd(4'h0);
    chk(rd, 32'h7004);
    // Sixteen taken branches and one invalid form so far
    reg_rd(4'h6);
    chk(rd, 32'h00010010);
    reg_rd(4'h5);
    chk(rd, 32'h0);
    reg_rd(4'h7);
    chk(rd, 32'h0);
    #5;
    chk(reg_rdata, 32'h0);
    $display("Test register port done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    fail_count  = 0;
    comparisons = 0;
    rst         = 1'b1;
    reg_addr    = 4'h0;
    reg_wdata   = 32'h0;
    reg_write   = 1'b0;
    reg_read    = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(res_valid, 1'b0);
    chk(return_address_reg, 64'h0);
    chk(loop_count_reg, 64'h0);
    t_immediate();
    t_condition();
    t_decrement();
    t_register_targets();
    t_reg_port();
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule
